/* inc/pfc_defs.vh */
// Constants for the parallel flash host controller
`ifndef PFC_DEFS_VH
`define PFC_DEFS_VH
`define PFC_UNLOCK_ADDR1 17'h0_5555
`define PFC_UNLOCK_ADDR2 17'h0_2AAA
`define PFC_UNLOCK_DATA1 8'hAA
`define PFC_UNLOCK_DATA2 8'h55
`define PFC_CMD_SETUP 8'h80
`define PFC_CMD_ERASE 8'h10
`define PFC_CMD_LOCK 8'h40
`define PFC_CMD_PROGRAM 8'hA0
`define PFC_CMD_ID_ENTRY 8'h90
`define PFC_CMD_ID_EXIT 8'hF0
`define PFC_LOCK_STATUS_ADDR 17'h0_0002
`define PFC_BOOT_LAST_ADDR 17'h0_1FFF
`define PFC_ERASED_BYTE 8'hFF
`define PFC_OP_READ 3'h0
`define PFC_OP_PROGRAM 3'h1
`define PFC_OP_ERASE 3'h2
`define PFC_OP_LOCK 3'h3
`define PFC_OP_ID_ENTRY 3'h4
`define PFC_OP_ID_EXIT 3'h5
`define PFC_OP_ID_EXIT_SHORT 3'h6
`define PFC_OP_LOCK_QUERY 3'h7
// Strobe low time: well above the 15 ns glitch filter of the flash
`define PFC_STROBE_NS 60
// Read access settle time before sampling the data bus
`define PFC_ACCESS_NS 120
`define PFC_CLK_NS 4
`endif

/* core/pfc_seq_rom.v */
// Command sequence table: address and data of each write cycle
`timescale 1ns/1ns
`include "pfc_defs.vh"
module pfc_seq_rom (
  input wire clock_in,
  input wire [2:0] op_in,
  input wire [2:0] step_in,
  input wire [7:0] user_data_in,
  input wire [16:0] user_addr_in,
  output reg [16:0] addr_out,
  output reg [7:0] data_out
);
  reg [16:0] a;
  reg [7:0] d;
  always @* begin
    a = `PFC_UNLOCK_ADDR1;
    d = `PFC_UNLOCK_DATA1;
    if (op_in == `PFC_OP_ID_EXIT_SHORT) begin
      a = user_addr_in;
      d = `PFC_CMD_ID_EXIT;
    end else begin
      case (step_in)
        3'h0: begin
          a = `PFC_UNLOCK_ADDR1;
          d = `PFC_UNLOCK_DATA1;
        end
        3'h1, 3'h4: begin
          a = `PFC_UNLOCK_ADDR2;
          d = `PFC_UNLOCK_DATA2;
        end
        3'h2: begin
          case (op_in)
            `PFC_OP_PROGRAM: d = `PFC_CMD_PROGRAM;
            `PFC_OP_ID_ENTRY, `PFC_OP_LOCK_QUERY: d = `PFC_CMD_ID_ENTRY;
            `PFC_OP_ID_EXIT: d = `PFC_CMD_ID_EXIT;
            default: d = `PFC_CMD_SETUP;
          endcase
        end
        3'h3: begin
          if (op_in == `PFC_OP_PROGRAM) begin
            a = user_addr_in;
            d = user_data_in;
          end
        end
        3'h5: begin
          d = (op_in == `PFC_OP_LOCK) ? `PFC_CMD_LOCK : `PFC_CMD_ERASE;
        end
        default: begin
          a = `PFC_UNLOCK_ADDR1;
          d = `PFC_UNLOCK_DATA1;
        end
      endcase
    end
  end
  always @(posedge clock_in) begin
    addr_out <= a;
    data_out <= d;
  end
endmodule

/* core/pfc_host.v */
// Host controller that drives a byte-wide parallel flash over its pins
// How it works
// - Chip erase is six unlock-prefixed writes ending 5555/10.
// - Byte program is three writes ending 5555/A0, then address and data.
// - Boot lockout is six writes ending 5555/40.
// - Identification entry is three writes ending 5555/90.
// - Identification exit is three writes ending F0, or one F0 write.
`timescale 1ns/1ns
`include "pfc_defs.vh"
module pfc_host #(
  parameter STROBE_CYC = (`PFC_STROBE_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS,
  parameter ACCESS_CYC = (`PFC_ACCESS_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS
) (
  input wire clock_in,
  input wire rst_b_in,
  input wire start_in,
  input wire [2:0] op_in,
  input wire [16:0] addr_in,
  input wire [7:0] wdata_in,
  output reg busy_out,
  output reg done_out,
  output reg error_out,
  output reg [7:0] rdata_out,
  output reg locked_out,
  output reg chip_sel_b_out,
  output reg out_en_b_out,
  output reg write_b_out,
  output reg [16:0] byte_address_out,
  output reg [7:0] data_bus_out,
  output reg data_bus_oe_out,
  input wire [7:0] data_bus_in
);
  localparam S_IDLE = 3'h0;
  localparam S_SETUP = 3'h1;
  localparam S_WLOW = 3'h2;
  localparam S_WHOLD = 3'h3;
  localparam S_RLOW = 3'h4;
  localparam S_RGAP = 3'h5;
  localparam S_DONE = 3'h6;
  localparam S_LOAD = 3'h7;
  reg [2:0] state;
  reg [2:0] op;
  reg [2:0] step;
  reg [16:0] uaddr;
  reg [7:0] udata;
  reg [7:0] cnt;
  reg poll_phase;
  reg have_prev;
  reg [7:0] prev;
  reg [7:0] s1;
  reg [7:0] s2;
  reg [7:0] s3;
  wire [16:0] seq_addr;
  wire [7:0] seq_data;
  wire [2:0] last_step;
  wire in_boot;
  wire [7:0] rd;

  pfc_seq_rom u_rom (
    .clock_in(clock_in),
    .op_in(op),
    .step_in(step),
    .user_data_in(udata),
    .user_addr_in(uaddr),
    .addr_out(seq_addr),
    .data_out(seq_data)
  );

  function [2:0] pfc_last;
    input [2:0] o;
    begin
      case (o)
        `PFC_OP_PROGRAM: pfc_last = 3'h3;
        `PFC_OP_ERASE, `PFC_OP_LOCK: pfc_last = 3'h5;
        `PFC_OP_ID_EXIT_SHORT: pfc_last = 3'h0;
        default: pfc_last = 3'h2;
      endcase
    end
  endfunction

  assign last_step = pfc_last(op);
  assign in_boot = (uaddr <= `PFC_BOOT_LAST_ADDR);
  // Bus value accepted only when the last two synchroniser stages agree
  assign rd = s3;

  always @(posedge clock_in) begin
    s1 <= data_bus_in;
    s2 <= s1;
    s3 <= s2;
  end

  always @(posedge clock_in) begin
    if (!rst_b_in) begin
      state <= S_IDLE;
      op <= `PFC_OP_READ;
      step <= 3'h0;
      uaddr <= 17'h0_0000;
      udata <= 8'h00;
      cnt <= 8'h00;
      poll_phase <= 1'b0;
      have_prev <= 1'b0;
      prev <= 8'h00;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      error_out <= 1'b0;
      rdata_out <= 8'h00;
      locked_out <= 1'b0;
      chip_sel_b_out <= 1'b1;
      out_en_b_out <= 1'b1;
      write_b_out <= 1'b1;
      byte_address_out <= 17'h0_0000;
      data_bus_out <= 8'h00;
      data_bus_oe_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      case (state)
        S_IDLE: begin
          // Requests while busy are ignored
          if (start_in) begin
            op <= op_in;
            uaddr <= addr_in;
            udata <= wdata_in;
            step <= 3'h0;
            poll_phase <= 1'b0;
            have_prev <= 1'b0;
            error_out <= 1'b0;
            busy_out <= 1'b1;
            if (op_in == `PFC_OP_READ) begin
              state <= S_SETUP;
              poll_phase <= 1'b1;
            end else if (op_in == `PFC_OP_PROGRAM && locked_out &&
                         addr_in <= `PFC_BOOT_LAST_ADDR) begin
              error_out <= 1'b1;
              busy_out <= 1'b0;
              done_out <= 1'b1;
            end else begin
              state <= S_LOAD;
            end
          end
        end
        S_SETUP: begin
          // Address and strobes settle a cycle apart to stay glitch free
          cnt <= 8'h00;
          out_en_b_out <= 1'b1;
          if (poll_phase) begin
            byte_address_out <= (op == `PFC_OP_LOCK_QUERY) ?
              `PFC_LOCK_STATUS_ADDR : uaddr;
            data_bus_oe_out <= 1'b0;
            chip_sel_b_out <= 1'b0;
            state <= S_RLOW;
          end else begin
            byte_address_out <= seq_addr;
            data_bus_out <= seq_data;
            data_bus_oe_out <= 1'b1;
            chip_sel_b_out <= 1'b0;
            state <= S_WLOW;
          end
        end
        S_WLOW: begin
          write_b_out <= 1'b0;
          cnt <= cnt + 8'h01;
          if (cnt == STROBE_CYC[7:0]) begin
            write_b_out <= 1'b1;
            cnt <= 8'h00;
            state <= S_WHOLD;
          end
        end
        S_WHOLD: begin
          // Data held one cycle past the rising strobe
          chip_sel_b_out <= 1'b1;
          data_bus_oe_out <= 1'b0;
          if (step == last_step) begin
            if (op == `PFC_OP_ID_EXIT || op == `PFC_OP_ID_EXIT_SHORT ||
                op == `PFC_OP_ID_ENTRY) begin
              state <= S_DONE;
            end else begin
              poll_phase <= 1'b1;
              state <= S_SETUP;
            end
          end else begin
            step <= step + 3'h1;
            state <= S_LOAD;
          end
        end
        S_RLOW: begin
          out_en_b_out <= 1'b0;
          cnt <= cnt + 8'h01;
          // Late settle waits for the synchroniser instead of a full wrap
          if (cnt >= ACCESS_CYC[7:0] && s2 == s3) begin
            out_en_b_out <= 1'b1;
            chip_sel_b_out <= 1'b1;
            prev <= rd;
            have_prev <= 1'b1;
            cnt <= 8'h00;
            state <= S_RGAP;
            if (op == `PFC_OP_READ) begin
              rdata_out <= rd;
              state <= S_DONE;
            end else if (op == `PFC_OP_LOCK_QUERY) begin
              locked_out <= rd[0];
              rdata_out <= rd;
              // Leave identification mode again with the short exit
              op <= `PFC_OP_ID_EXIT_SHORT;
              step <= 3'h0;
              poll_phase <= 1'b0;
              state <= S_LOAD;
            end else if (have_prev && prev[6] == rd[6]) begin
              rdata_out <= rd;
              state <= S_DONE;
              if (op == `PFC_OP_LOCK) begin
                locked_out <= 1'b1;
              end
              if (op == `PFC_OP_PROGRAM &&
                  (rd != udata || rd[7] != udata[7])) begin
                error_out <= 1'b1;
              end
              if (op == `PFC_OP_ERASE && rd != `PFC_ERASED_BYTE &&
                  !(locked_out && in_boot)) begin
                error_out <= 1'b1;
              end
            end
          end
        end
        S_RGAP: begin
          // Output enable must rise between reads for the toggle to advance
          state <= S_SETUP;
        end
        S_LOAD: begin
          // Sequence table output is registered: it lags op and step a cycle
          state <= S_SETUP;
        end
        S_DONE: begin
          chip_sel_b_out <= 1'b1;
          out_en_b_out <= 1'b1;
          busy_out <= 1'b0;
          done_out <= 1'b1;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule

/* testbench/pfc_host_properties.sv */
// Assertion checker on the host controller pins
`timescale 1ns/1ns
`include "pfc_defs.vh"
module pfc_host_checker (
  input wire clock_in,
  input wire rst_b_in,
  input wire start_in,
  input wire [2:0] op_in,
  input wire [16:0] addr_in,
  input wire busy_out,
  input wire done_out,
  input wire error_out,
  input wire locked_out,
  input wire chip_sel_b_out,
  input wire out_en_b_out,
  input wire write_b_out,
  input wire [16:0] byte_address_out,
  input wire [7:0] data_bus_out,
  input wire data_bus_oe_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  write_no_read_a:
    assert property (!write_b_out |-> out_en_b_out) else $error("oe in write");
  write_sel_a:
    assert property (!write_b_out |-> !chip_sel_b_out) else $error("we no cs");
  read_pins_a:
    assert property (!out_en_b_out |-> !chip_sel_b_out && write_b_out &&
      !data_bus_oe_out) else $error("bad read pins");
  strobe_width_a:
    assert property ($fell(write_b_out) |-> !write_b_out [*4])
    else $error("short strobe");
  write_hold_a:
    assert property ((!write_b_out || $rose(write_b_out)) |->
      $stable(byte_address_out) && $stable(data_bus_out) && data_bus_oe_out)
    else $error("write moved");
  done_pulse_a:
    assert property (done_out |=> !done_out && !busy_out)
    else $error("done not pulse");
  start_taken_a:
    assert property (start_in && !busy_out |=> busy_out || done_out)
    else $error("start lost");
  boot_refuse_a:
    assert property (start_in && !busy_out && locked_out &&
      op_in == `PFC_OP_PROGRAM && addr_in <= `PFC_BOOT_LAST_ADDR |->
      ##[1:2] (done_out && error_out && chip_sel_b_out))
    else $error("boot not refused");
endmodule
bind pfc_host pfc_host_checker u_chk (.clock_in(clock_in),
  .rst_b_in(rst_b_in), .start_in(start_in), .op_in(op_in),
  .addr_in(addr_in), .busy_out(busy_out), .done_out(done_out),
  .error_out(error_out), .locked_out(locked_out),
  .chip_sel_b_out(chip_sel_b_out), .out_en_b_out(out_en_b_out),
  .write_b_out(write_b_out), .byte_address_out(byte_address_out),
  .data_bus_out(data_bus_out), .data_bus_oe_out(data_bus_oe_out));

/* testbench/pfc_flash_model.sv */
// Behavioural byte-wide flash device
`timescale 1ns/1ns
module pfc_flash_model #(
  parameter BUSY_NS = 400,
  parameter MFR = 8'hA5, // Arbitrary value
  parameter DEV = 8'h3C // Arbitrary value
) (
  input wire cs_b_in,
  input wire oe_b_in,
  input wire we_b_in,
  input wire [16:0] addr_in,
  input wire [7:0] data_in,
  output wire [7:0] data_out
);
  reg [7:0] mem [0:131071];
  reg [7:0] q, rel, last;
  reg [16:0] la;
  reg [2:0] st;
  reg busy, lock, idm, tog;
  time t0;
  integer i;
  wire stb = cs_b_in | we_b_in;
  wire rd = !cs_b_in && !oe_b_in && we_b_in;
  wire u = st == 3'h1 || st == 3'h4;
  initial begin
    for (i = 0; i < 131072; i = i + 1) mem[i] = 8'hFF;
    {busy, lock, idm, tog, st, rel, last} = 0;
  end
  always @* begin
    if (busy) q = {~last[7], tog, 6'h00};
    else if (!idm) q = mem[addr_in];
    else if (addr_in == 17'h0_0002) q = {7'h00, lock};
    else q = addr_in[0] ? DEV : MFR;
  end
  // Released bus shows the inverse so a stale sample cannot pass
  assign data_out = rd ? q : rel;
  always @(negedge rd) rel = ~q;
  always @(posedge rd) if (busy) tog = ~tog;
  always @(negedge stb) begin
    la = addr_in;
    t0 = $time;
  end
  always @(posedge stb) if (oe_b_in && !busy && $time - t0 >= 15) begin
    if (st == 3'h6) begin
      if (!(lock && la <= 17'h0_1FFF)) mem[la] = mem[la] & data_in;
      last = data_in;
      busy <= 1'b1;
      busy <= #BUSY_NS 1'b0;
      st = 3'h0;
    end else if (st == 3'h2 && la == 17'h0_5555) begin
      st = data_in == 8'h80 ? 3'h3 : data_in == 8'hA0 ? 3'h6 : 3'h0;
      if (data_in == 8'h90) idm = 1'b1;
      if (data_in == 8'hF0) idm = 1'b0;
    end else if (st == 3'h5 && la == 17'h0_5555) begin
      st = 3'h0;
      if (data_in == 8'h40) lock = 1'b1;
      if (data_in == 8'h10) begin
        for (i = 0; i < 131072; i = i + 1)
          if (!(lock && i < 8192)) mem[i] = 8'hFF;
        last = 8'hFF;
        busy <= 1'b1;
        busy <= #BUSY_NS 1'b0;
      end
    end else if (st != 3'h2 && st != 3'h5 && la == (u ? 17'h0_2AAA :
        17'h0_5555) && data_in == (u ? 8'h55 : 8'hAA)) st = st + 3'h1;
    else begin
      if (data_in == 8'hF0) idm = 1'b0;
      st = 3'h0;
    end
  end
endmodule

/* testbench/tb_pfc_host.sv */
// Self-checking bench for the flash host controller
`timescale 1ns/1ns
module tb_pfc_host;
  reg clock_in, rst_b_in, start_in;
  reg [2:0] op_in;
  reg [16:0] addr_in;
  reg [7:0] wdata_in;
  wire busy, done, err, lkd, cs_b, oe_b, we_b, doe;
  wire [7:0] rdata, dout, fq;
  wire [16:0] ba;
  wire [7:0] bus = doe ? dout : fq;
  integer num_errors, tests_run;
  pfc_host #(.STROBE_CYC(5), .ACCESS_CYC(6)) dut (.clock_in(clock_in),
    .rst_b_in(rst_b_in), .start_in(start_in), .op_in(op_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .busy_out(busy),
    .done_out(done), .error_out(err), .rdata_out(rdata),
    .locked_out(lkd), .chip_sel_b_out(cs_b), .out_en_b_out(oe_b),
    .write_b_out(we_b), .byte_address_out(ba), .data_bus_out(dout),
    .data_bus_oe_out(doe), .data_bus_in(bus));
  pfc_flash_model fm (.cs_b_in(cs_b), .oe_b_in(oe_b), .we_b_in(we_b),
    .addr_in(ba), .data_in(bus), .data_out(fq));
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  task chk(input [63:0] nm, input [7:0] e, input [7:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("mismatch %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task req(input [2:0] op, input [16:0] a, input [7:0] d, input e);
    integer n;
    begin
      @(negedge clock_in);
      op_in = op;
      addr_in = a;
      wdata_in = d;
      start_in = 1'b1;
      @(negedge clock_in);
      start_in = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 9000) begin
        @(negedge clock_in);
        n = n + 1;
      end
      tests_run = tests_run + 1;
      if (n >= 9000) begin
        num_errors = num_errors + 1;
        $display("mismatch done expected 1 seen 0");
      end
      chk("error", {7'h00, e}, {7'h00, err});
    end
  endtask
  task rd(input [16:0] a, input [7:0] e);
    begin
      req(3'h0, a, 8'h00, 1'b0);
      chk("rdata", e, rdata);
    end
  endtask
  task t_program;
    begin
      req(3'h1, 17'h1_0000, 8'h5A, 1'b0);
      rd(17'h1_0000, 8'h5A);
      req(3'h1, 17'h1_0000, 8'hF0, 1'b1);
      rd(17'h1_0000, 8'h50);
    end
  endtask
  task t_erase;
    begin
      req(3'h2, 17'h1_0000, 8'h00, 1'b0);
      rd(17'h1_0000, 8'hFF);
    end
  endtask
  task t_ident;
    begin
      req(3'h4, 17'h0_0000, 8'h00, 1'b0);
      rd(17'h0_0000, 8'hA5);
      rd(17'h0_0001, 8'h3C);
      req(3'h5, 17'h0_0000, 8'h00, 1'b0);
      rd(17'h0_0001, 8'hFF);
      req(3'h4, 17'h0_0000, 8'h00, 1'b0);
      req(3'h6, 17'h1_2345, 8'h00, 1'b0);
      rd(17'h0_0000, 8'hFF);
    end
  endtask
  task t_lock;
    begin
      req(3'h1, 17'h0_0100, 8'h33, 1'b0);
      req(3'h7, 17'h0_0000, 8'h00, 1'b0);
      chk("lock", 8'h00, {6'h00, lkd, rdata[0]});
      req(3'h3, 17'h0_0000, 8'h00, 1'b0);
      req(3'h7, 17'h0_0000, 8'h00, 1'b0);
      chk("lock", 8'h03, {6'h00, lkd, rdata[0]});
      req(3'h1, 17'h0_1FFF, 8'h00, 1'b1);
      req(3'h1, 17'h0_2000, 8'h0F, 1'b0);
      req(3'h2, 17'h1_0000, 8'h00, 1'b0);
      rd(17'h0_0100, 8'h33);
      rd(17'h0_2000, 8'hFF);
    end
  endtask
  task wrap_up;
    begin
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    {num_errors, tests_run} = 0;
    {rst_b_in, start_in, op_in, addr_in, wdata_in} = 0;
    repeat (6) @(negedge clock_in);
    rst_b_in = 1'b1;
    chk("pins", 8'h0E, {4'h0, cs_b, oe_b, we_b, doe});
    t_program;
    t_erase;
    t_ident;
    t_lock;
    wrap_up;
  end
  initial begin
    #200000;
    num_errors = num_errors + 1;
    wrap_up;
  end
endmodule
